// >>> verilog/irq_map_pkg.sv
package irq_map_pkg;
    localparam int unsigned NUM_VEC      = 64;
    localparam int unsigned VEC_W        = 6;
    localparam int unsigned LVL_W        = 2;
    localparam int unsigned PADDR_W      = 21;
    localparam int unsigned BASE_W       = 21;
    localparam int unsigned ENTRY_SHIFT  = 1;
    localparam int unsigned TARGET_W     = 19;
    localparam int unsigned RANK_W       = 3;

    // fixed vector numbers
    localparam logic [5:0] VEC_RESET       = 6'h00;
    localparam logic [5:0] VEC_WDOG_RESET  = 6'h01;
    localparam logic [5:0] VEC_CORE_FIRST  = 6'h02;
    localparam logic [5:0] VEC_CORE_LAST   = 6'h05;
    localparam logic [5:0] VEC_DBG_FIRST   = 6'h06;
    localparam logic [5:0] VEC_DBG_LAST    = 6'h0A;
    localparam logic [5:0] VEC_SOFT2       = 6'h0B;
    localparam logic [5:0] VEC_SOFT1       = 6'h0C;
    localparam logic [5:0] VEC_SOFT0       = 6'h0D;
    localparam logic [5:0] VEC_LOW_VOLTAGE = 6'h0F;
    localparam logic [5:0] VEC_PLL         = 6'h10;
    localparam logic [5:0] VEC_PERIPH_FIRST = 6'h11;
    localparam logic [5:0] VEC_LOWEST_SOFT = 6'h3F;

    // reserved vectors as a 64-bit mask (0,1 are reset overlays, 14, 30-31, 36-39, 49-52)
    localparam logic [63:0] RESERVED_MASK = 64'h001E_00F0_C000_4003;

    localparam logic [20:0] BASE_RESET    = 21'h00_0000;
    localparam logic [1:0]  LVL_RESET     = 2'h0;

    typedef struct packed {
        logic                 valid;
        logic [VEC_W-1:0]     vector;
        logic [RANK_W-1:0]    rank;
        logic [PADDR_W-1:0]   fetch_addr;
    } irq_grant_t;
endpackage

// >>> verilog/irq_level_ram.sv
// per-vector level storage, registered read-out of the whole table
module irq_level_ram #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned WIDTH = 2
) (
    // clock and reset
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst_n,
    // write port
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_idx,
    input  wire logic [WIDTH-1:0]         i_wr_data,
    // full table
    output logic      [DEPTH*WIDTH-1:0]   o_table
);
    import irq_map_pkg::*;

    typedef struct packed {
        logic [DEPTH*WIDTH-1:0] mem;
    } ram_state_t;

    ram_state_t s_q;
    ram_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (i_wr_en) begin
            s_d.mem[i_wr_idx*WIDTH +: WIDTH] = i_wr_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_table = s_q.mem;
endmodule

// >>> verilog/vectored_irq_priority_map.sv
// How it works
// - level 3 requests always beat level 2, and so down the levels.
// - within one level the smallest vector number wins.
// - fetch address is the software vector base plus the entry offset.
// - each entry is two words, offset is twice the vector number.
// - a vector entry reaches only a 19-bit target address.
// - base zero puts reset at 0 and watchdog reset at 2.
// - core exceptions use vectors 2 to 5 at fixed level 3.
// - debug sources use vectors 6 to 10 with levels 1 to 3.
// - low voltage on 15, PLL on 16, levels 1 to 3.
// - software sets each programmable source's level within its range.
// - flash requests on 17 to 19; peripherals take levels 0 to 2.
// - serial comm port requests on vectors 32 to 35.
// - converter requests on vectors 58, 59 and 60.
// - lowest soft interrupt on vector 63, level below all others.
// - serial peripheral port requests on vectors 28 and 29.
module vectored_irq_priority_map (
    // clock and reset
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst_n,
    // request lines, one bit per vector number
    input  wire logic [63:0]                  i_req,
    // software configuration
    input  wire logic                         i_base_wr,
    input  wire logic [irq_map_pkg::BASE_W-1:0] i_vector_table_base,
    input  wire logic                         i_lvl_wr,
    input  wire logic [5:0]                   i_lvl_vec,
    input  wire logic [1:0]                   i_lvl_val,
    // reset-kind fetch select
    input  wire logic                         i_wdog_reset,
    // winner towards the core
    output irq_map_pkg::irq_grant_t           o_grant,
    output logic [irq_map_pkg::PADDR_W-1:0]   o_reset_fetch_addr,
    output logic [irq_map_pkg::BASE_W-1:0]    o_vector_table_base
);
    import irq_map_pkg::*;

    typedef struct packed {
        logic [BASE_W-1:0] base;
        irq_grant_t        grant;
        logic [PADDR_W-1:0] rst_addr;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;
    logic [NUM_VEC*LVL_W-1:0] lvl_table;
    logic                     lvl_ok;

    // vector class decoders, shared by the write check and the ranking
    function automatic logic is_core_exc(input logic [5:0] v);
        return v >= VEC_CORE_FIRST && v <= VEC_CORE_LAST;
    endfunction

    function automatic logic is_debug(input logic [5:0] v);
        return v >= VEC_DBG_FIRST && v <= VEC_DBG_LAST;
    endfunction

    // sources whose level floor is 1 rather than 0
    function automatic logic is_high_floor(input logic [5:0] v);
        return is_debug(v) || v == VEC_LOW_VOLTAGE || v == VEC_PLL;
    endfunction

    function automatic logic is_periph(input logic [5:0] v);
        return v >= VEC_PERIPH_FIRST && v < VEC_LOWEST_SOFT && !RESERVED_MASK[v];
    endfunction

    // per-source allowed level range, used for writes and for ranking
    function automatic logic [1:0] lvl_min(input logic [5:0] v);
        if (is_high_floor(v)) begin
            return 2'h1;
        end
        return 2'h0;
    endfunction

    function automatic logic lvl_programmable(input logic [5:0] v);
        return is_high_floor(v) || is_periph(v);
    endfunction

    // a level outside the source's range is dropped, not clipped
    function automatic logic lvl_in_range(input logic [5:0] v, input logic [1:0] l);
        return lvl_programmable(v) && l >= lvl_min(v) && l <= lvl_min(v) + 2'h2;
    endfunction

    // rank 0 is level -1, rank n+1 is level n; fixed sources never read the table
    function automatic logic [RANK_W-1:0] rank_of(input logic [5:0] v, input logic [1:0] lv);
        logic [RANK_W-1:0] r;
        r = RANK_W'({1'b0, lv} + 3'h1);
        if (is_core_exc(v)) begin
            r = 3'h4;
        end else if (v == VEC_SOFT2) begin
            r = 3'h3;
        end else if (v == VEC_SOFT1) begin
            r = 3'h2;
        end else if (v == VEC_SOFT0) begin
            r = 3'h1;
        end else if (v == VEC_LOWEST_SOFT) begin
            r = 3'h0;
        end
        return r;
    endfunction

    function automatic logic [PADDR_W-1:0] entry_offset(input logic [5:0] v);
        return PADDR_W'({v, 1'b0});
    endfunction

    // entry address: base plus offset, cut to the reachable 19 bits
    // limitation: a base near the top of program space wraps inside that window
    function automatic logic [PADDR_W-1:0] entry_addr(input logic [BASE_W-1:0] b,
                                                      input logic [5:0] v);
        logic [PADDR_W-1:0] sum;
        sum = b + entry_offset(v);
        return PADDR_W'(sum[TARGET_W-1:0]);
    endfunction

    assign lvl_ok = i_lvl_wr && lvl_in_range(i_lvl_vec, i_lvl_val);

    // level table is registered, so a write steers ranking one cycle later

    irq_level_ram #(
        .DEPTH (NUM_VEC),
        .WIDTH (LVL_W)
    ) u_lvl (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (lvl_ok),
        .i_wr_idx  (i_lvl_vec),
        .i_wr_data (i_lvl_val),
        .o_table   (lvl_table)
    );

    always_comb begin
        logic [1:0]        lv;
        logic [RANK_W-1:0] rk;
        logic              found;
        logic [5:0]        win_v;
        logic [RANK_W-1:0] win_r;
        logic [5:0]        rst_v;

        lv    = 2'h0;
        rk    = '0;
        found = 1'b0;
        win_v = '0;
        win_r = '0;
        rst_v = VEC_RESET;
        s_d   = s_q;

        if (i_base_wr) begin
            s_d.base = i_vector_table_base;
        end

        // scan ascending, replace only on strictly higher rank
        for (int i = 0; i < NUM_VEC; i++) begin
            if (i_req[i] && !RESERVED_MASK[i]) begin
                lv = lvl_table[i*LVL_W +: LVL_W];

                // unprogrammed debug/low-voltage slots read 0; floor them to 1
                if (lv < lvl_min(6'(i))) begin
                    lv = lvl_min(6'(i));
                end

                rk = rank_of(6'(i), lv);

                // equal rank keeps the earlier, smaller vector
                if (!found || rk > win_r) begin
                    found = 1'b1;
                    win_v = 6'(i);
                    win_r = rk;
                end
            end
        end

        // vector is the request bit index
        s_d.grant.valid  = found;
        s_d.grant.vector = win_v;
        s_d.grant.rank   = win_r;

        // fetch address follows a base written in the same cycle
        s_d.grant.fetch_addr = entry_addr(s_d.base, win_v);

        // reset overlays vectors 0 and 1
        if (i_wdog_reset) begin
            rst_v = VEC_WDOG_RESET;
        end
        s_d.rst_addr = entry_addr(s_d.base, rst_v);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q.base     <= BASE_RESET;
            s_q.grant    <= '0;
            s_q.rst_addr <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // every output comes straight from a flip-flop
    assign o_grant             = s_q.grant;
    assign o_reset_fetch_addr  = s_q.rst_addr;
    assign o_vector_table_base = s_q.base;
endmodule

// >>> tb/core_fetch_model.sv
// core side: takes the winning fetch address and the entry kind it finds there
module core_fetch_model
    import irq_map_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire irq_grant_t i_grant,
    output logic [20:0]     o_taken_addr,
    output logic            o_sub_jump
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_taken_addr <= 21'h0;
            o_sub_jump   <= 1'b0;
        end else if (i_grant.valid) begin
            o_taken_addr <= i_grant.fetch_addr;
            o_sub_jump   <= (i_grant.vector > 6'h01);
        end
    end
endmodule

// >>> tb/irq_map_props.sv
module irq_map_props
    import irq_map_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic [63:0] i_req,
    input wire logic        i_base_wr,
    input wire logic [20:0] i_vector_table_base,
    input wire logic        i_wdog_reset,
    input wire irq_grant_t  o_grant,
    input wire logic [20:0] o_reset_fetch_addr,
    input wire logic [20:0] o_vector_table_base
);
    logic [63:0] req_q;
    logic        wdog_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q  <= 64'h0;
            wdog_q <= 1'b0;
        end else begin
            req_q  <= i_req;
            wdog_q <= i_wdog_reset;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence base_wr_s;
        i_base_wr ##0 1'b1;
    endsequence
    reserved_never_a: assert property (
        o_grant.valid |-> !RESERVED_MASK[o_grant.vector]) else $error("reserved won");
    grant_pending_a: assert property (
        o_grant.valid |-> req_q[o_grant.vector]) else $error("idle vector won");
    grant_valid_a: assert property (
        o_grant.valid == |(req_q & ~RESERVED_MASK)) else $error("valid wrong");
    fetch_offset_a: assert property (
        o_grant.valid |-> o_grant.fetch_addr ==
        {2'b00, 19'(o_vector_table_base + {14'h0, o_grant.vector, 1'b0})}) else $error("fetch");
    core_wins_a: assert property (
        req_q[2] |-> o_grant.vector == 6'h02 && o_grant.rank == 3'h4) else $error("core lost");
    soft_lowest_a: assert property (
        o_grant.valid && o_grant.vector == 6'h3F |-> o_grant.rank == 3'h0) else $error("rank");
    periph_range_a: assert property (
        o_grant.valid && o_grant.vector inside {[17:62]} |-> o_grant.rank inside {[1:3]})
        else $error("periph rank");
    reset_entry_a: assert property (
        o_reset_fetch_addr == {2'b00, 19'(o_vector_table_base + (wdog_q ? 21'h2 : 21'h0))})
        else $error("reset entry");
    base_take_a: assert property (
        base_wr_s |=> o_vector_table_base == $past(i_vector_table_base)) else $error("base");
endmodule
bind vectored_irq_priority_map irq_map_props u_props (.*);

// >>> tb/vectored_irq_priority_map_tb_top.sv
module vectored_irq_priority_map_tb_top
    import irq_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_n, base_wr, lvl_wr, wdog, sub_jump;
    logic [63:0] req;
    logic [20:0] base, rst_addr, cur_base, taken;
    logic [5:0]  lvl_vec;
    logic [1:0]  lvl_val;
    irq_grant_t  grant;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    vectored_irq_priority_map uut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_req(req),
        .i_base_wr(base_wr), .i_vector_table_base(base), .i_lvl_wr(lvl_wr),
        .i_lvl_vec(lvl_vec), .i_lvl_val(lvl_val), .i_wdog_reset(wdog), .o_grant(grant),
        .o_reset_fetch_addr(rst_addr), .o_vector_table_base(cur_base));
    core_fetch_model u_core (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_grant(grant),
        .o_taken_addr(taken), .o_sub_jump(sub_jump));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic logic [20:0] fa(input logic [5:0] v);
        return {2'b00, 19'(base + {14'h0, v, 1'b0})};
    endfunction
    task automatic step(input logic [63:0] r);
        req = r;
        @(negedge sys_clk);
    endtask
    task automatic set_base(input logic [20:0] b);
        base_wr = 1'b1;
        base = b;
        @(negedge sys_clk);
        base_wr = 1'b0;
    endtask
    task automatic set_lvl(input logic [5:0] v, input logic [1:0] l);
        lvl_wr = 1'b1;
        lvl_vec = v;
        lvl_val = l;
        @(negedge sys_clk);
        lvl_wr = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic win(input logic [63:0] r, input logic [5:0] v, input logic [2:0] k);
        step(r);
        chk(grant.vector, v);
        chk(grant.rank, k);
    endtask
    // every vector alone: reserved ones stay silent, the rest map one to one
    task automatic t_map();
        set_base(21'h00_1000);
        for (int v = 0; v < 64; v++) begin
            step(64'h1 << v);
            chk(grant.valid, !RESERVED_MASK[v]);
            if (!RESERVED_MASK[v]) begin
                chk(grant.vector, v);
                chk(grant.fetch_addr, fa(v));
            end
        end
    endtask
    task automatic t_rank();
        win(64'h8000_0000_0002_0000, 6'd17, 3'h1);
        set_lvl(6'd45, 2'h2);
        set_lvl(6'd32, 2'h1);
        win(64'h0000_2001_0000_0000, 6'd45, 3'h3);
        set_lvl(6'd32, 2'h2);
        win(64'h0000_2001_0000_0000, 6'd32, 3'h3);
        set_lvl(6'd45, 2'h3);
        win(64'h0000_2001_0000_0000, 6'd32, 3'h3);
        set_lvl(6'd7, 2'h3);
        set_lvl(6'd7, 2'h0);
        win(64'h0000_2000_0000_0080, 6'd7, 3'h4);
        set_lvl(6'd4, 2'h0);
        win(64'h0000_2000_0000_0010, 6'd4, 3'h4);
        set_lvl(6'd16, 2'h3);
        set_lvl(6'd7, 2'h1);
        win(64'h0000_0000_0001_0080, 6'd16, 3'h4);
    endtask
    task automatic t_base();
        set_base(21'h0);
        step(64'h0);
        chk(rst_addr, 21'h0);
        wdog = 1'b1;
        step(64'h0);
        chk(rst_addr, 21'h2);
        set_base(21'h1F_FFF0);
        chk(cur_base, 21'h1F_FFF0);
        step(64'h1 << 45);
        chk(grant.fetch_addr, fa(6'd45));
        step(64'h0);
        chk(taken, fa(6'd45));
        chk(sub_jump, 1'b1);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        {rst_n, base_wr, lvl_wr, wdog, req, base, lvl_vec, lvl_val} = '0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        t_map();
        t_rank();
        t_base();
        print_verdict();
    end
endmodule
